// ### sim/slave_checker_asserts.sv
// Concurrent checks on the backplane and chip ports of the slave.
`timescale 1ns/1ps
module slave_checker (
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic        AS_N,
  input wire logic        IACK_N,
  input wire logic        IACKIN_N,
  input wire logic [5:0]  AM,
  input wire logic [15:1] ADDR,
  input wire logic [7:0]  CHIP_DIN,
  input wire logic [7:0]  D_O,
  input wire logic        D_OE,
  input wire logic        DTACK_N_OE,
  input wire logic        IACKOUT_N,
  input wire logic [7:1]  IRQ_N_OE,
  input wire logic        CHIP_CS_N,
  input wire logic [2:0]  CHIP_RS
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////
  a_one_line: assert property ($onehot0(IRQ_N_OE))
    else $error("more than one request line driven");
  a_wide_ignored: assert property (!AS_N && IACK_N &&
    AM != vme_cfg_pkg::AM_SHORT_SUPER && AM != vme_cfg_pkg::AM_SHORT_USER
    |=> CHIP_CS_N [*2]) else $error("foreign modifier reached the chip");
  a_rs_follow: assert property ($fell(CHIP_CS_N)
    |-> CHIP_RS == $past(ADDR[3:1])) else $error("register select wrong");
  a_strobe_len: assert property ($fell(CHIP_CS_N)
    |=> !CHIP_CS_N ##1 CHIP_CS_N) else $error("chip strobe length wrong");
  a_read_byte: assert property ($rose(D_OE) && IACK_N
    |-> D_O == $past(CHIP_DIN)) else $error("read byte not from chip");
  a_ans_release: assert property ($rose(DTACK_N_OE) && !IACK_N
    |-> IRQ_N_OE == 7'h00) else $error("request kept after answer");
  a_pass_cause: assert property (!IACKOUT_N
    |-> !$past(IACKIN_N) && !$past(AS_N)) else $error("chain out unprompted");
  a_pass_or_ans: assert property (!(DTACK_N_OE && !IACKOUT_N))
    else $error("answered and passed together");
  a_drop_ack: assert property ($past(AS_N) |-> !DTACK_N_OE)
    else $error("acknowledge held after strobe release");
  c_read: cover property ($rose(D_OE) && IACK_N);
  c_answer: cover property ($rose(DTACK_N_OE) && !IACK_N);
  c_pass: cover property ($fell(IACKOUT_N));
endmodule // slave_checker

bind vme_slave_interrupter slave_checker slave_checker_i (
  .CLK_SYS(CLK_SYS), .RST(RST), .AS_N(AS_N), .IACK_N(IACK_N),
  .IACKIN_N(IACKIN_N), .AM(AM), .ADDR(ADDR), .CHIP_DIN(CHIP_DIN),
  .D_O(D_O), .D_OE(D_OE), .DTACK_N_OE(DTACK_N_OE), .IACKOUT_N(IACKOUT_N),
  .IRQ_N_OE(IRQ_N_OE), .CHIP_CS_N(CHIP_CS_N), .CHIP_RS(CHIP_RS));

// ### sim/test_vme_slave_interrupter.sv
// Self-checking bench for the short I/O slave and interrupter.
`timescale 1ns/1ps
module test_vme_slave_interrupter;
  logic        clk, rst, chip_int, awvalid, wvalid, bready, arvalid, rready;
  logic        as_n, ds0_n, ds1_n, write_n, lword_n, iack_n, iackin_n, acc;
  logic        d_oe, dtack_oe, iackout_n, cs_n, rd_n, wr_n, irq, ack, pass;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [5:0]  am;
  logic [15:1] addr;
  logic [7:0]  d_i, d_o, chip_din, chip_dout, awaddr, araddr, wcap, rd;
  logic [7:1]  irq_oe;
  logic [3:0]  wstrb;
  logic [2:0]  rs, rscap;
  logic [31:0] wdata, rdata, cfg, v;
  logic [1:0]  bresp, rresp, r;
  logic [5:0]  ams [5] = '{6'h2D, 6'h29, 6'h3D, 6'h39, 6'h09};
  int          n_fail, n_checks;

  vme_slave_interrupter vme_slave_interrupter_i (
    .CLK_SYS(clk), .RST(rst), .AS_N(as_n), .DS0_N(ds0_n), .DS1_N(ds1_n),
    .WRITE_N(write_n), .LWORD_N(lword_n), .IACK_N(iack_n),
    .IACKIN_N(iackin_n), .AM(am), .ADDR(addr), .D_I(d_i), .D_O(d_o),
    .D_OE(d_oe), .DTACK_N_OE(dtack_oe), .IACKOUT_N(iackout_n),
    .IRQ_N_OE(irq_oe), .CHIP_CS_N(cs_n), .CHIP_RD_N(rd_n), .CHIP_WR_N(wr_n),
    .CHIP_RS(rs), .CHIP_DOUT(chip_dout), .CHIP_DIN(chip_din),
    .CHIP_INT(chip_int), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .IRQ(irq));

  vme_master vme_master_i (
    .clk(clk), .as_n(as_n), .ds0_n(ds0_n), .ds1_n(ds1_n), .write_n(write_n),
    .lword_n(lword_n), .iack_n(iack_n), .iackin_n(iackin_n), .am(am),
    .addr(addr), .d_i(d_i), .d_o(d_o), .dtack_oe(dtack_oe),
    .iackout_n(iackout_n));

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) if (!cs_n && !wr_n) wcap <= chip_dout;
  always @(posedge clk) if (!cs_n && !rd_n) rscap <= rs;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    chk(rdata, e);
    chk(rresp, er);
  endtask

  function automatic logic hit(input logic [5:0] m, input logic [15:0] a);
    return a[15:4] == cfg[15:4] && (m == 6'h2D || (m == 6'h29 && !cfg[0]));
  endfunction

  // Offsets run past the window end so its upper edge is crossed.
  task automatic slave_mix;
    logic [15:0] a;
    logic [7:0]  din, wd;
    logic [5:0]  m;
    logic        ds, wr;
    for (int i = 0; i < 24; i++) begin
      m = ams[$urandom_range(0, 4)];
      a = {cfg[15:4], 4'h0} + 16'($urandom_range(0, 31));
      ds = (i % 5) != 4;
      wr = 1'($urandom_range(0, 1));
      wd = 8'($urandom);
      din = 8'($urandom);
      chip_din <= din;
      vme_master_i.cyc(1'b0, ds, wr, m, a[15:1], wd, ack, pass, rd);
      chk(ack, hit(m, a) && ds);
      if (ack && wr) chk(wcap, wd);
      acc |= hit(m, a) && ds;
      if (ack && !wr) chk(rd, din);
      if (ack && !wr) chk(rscap, a[3:1]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (8000) @(posedge clk);
    n_fail++;
    test_done();
  end

  initial begin
    {rst, chip_int, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
    {awaddr, araddr, chip_din, wdata, wstrb} = 60'h0;
    n_fail = 0;
    n_checks = 0;
    acc = 1'b0;
    void'($urandom(83));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axr(8'h00, vme_cfg_pkg::CFG_RESET, 2'h0);
    axr(8'h08, 32'h0, 2'h0);
    axr(8'h10, 32'h0, vme_cfg_pkg::RESP_SLVERR);
    axw(8'h10, 32'h0);
    chk(r, vme_cfg_pkg::RESP_SLVERR);
    cfg = vme_cfg_pkg::CFG_RESET;
    slave_mix();
    cfg = {8'h5C, 8'h22, 12'($urandom), 4'h1};
    axw(8'h00, cfg);
    axr(8'h00, cfg, 2'h0);
    slave_mix();
    for (int ln = 1; ln < 8; ln++) begin
      v = 32'($urandom);
      cfg = {v[7:0], 1'b0, 3'(ln), 1'b0, 3'(ln), 12'h100, 4'h0};
      axw(8'h00, cfg);
      axw(8'h08, 32'hF);
      axr(8'h04, 32'(ln == 1 && acc), 2'h0);
      chip_int <= 1'b1;
      repeat (3) @(posedge clk);
      chk(irq_oe, 7'h01 << (ln - 1));
      chk(irq, 1'b1);
      vme_master_i.cyc(1'b1, 1'b1, 1'b0, 6'h2D, {12'h000, 3'(ln % 7 + 1)},
                       8'h00, ack, pass, rd);
      chk({ack, pass}, 2'b01);
      vme_master_i.cyc(1'b1, 1'b1, 1'b0, 6'h2D, {12'h000, 3'(ln)},
                       8'h00, ack, pass, rd);
      chk({ack, pass}, 2'b10);
      chk(rd, v[7:0]);
      chk(irq_oe, 7'h00);
      chip_int <= 1'b0;
      axr(8'h04, 32'hE, 2'h0);
      axr(8'h04, 32'h0, 2'h0);
      chk(irq, 1'b0);
    end
    test_done();
  end
endmodule // test_vme_slave_interrupter

// ### sim/vme_master.sv
// Backplane master and interrupt handler model facing the slave.
`timescale 1ns/1ps
module vme_master (
  input  wire logic        clk,
  output logic             as_n,
  output logic             ds0_n,
  output logic             ds1_n,
  output logic             write_n,
  output logic             lword_n,
  output logic             iack_n,
  output logic             iackin_n,
  output logic      [5:0]  am,
  output logic      [15:1] addr,
  output logic      [7:0]  d_i,
  input  wire logic [7:0]  d_o,
  input  wire logic        dtack_oe,
  input  wire logic        iackout_n
);
  initial begin
    {as_n, ds0_n, ds1_n, write_n, lword_n, iack_n, iackin_n} = 7'h7F;
    am = 6'h00;
    addr = 15'h0000;
    d_i = 8'h00;
  end
  // A cycle nobody answers ends after eight clocks, as a bus timer would.
  task automatic cyc(input logic ia, input logic ds, input logic wr,
                     input logic [5:0] m, input logic [15:1] a,
                     input logic [7:0] wd, output logic ack,
                     output logic pass, output logic [7:0] rd);
    int n;
    ack = 1'b0;
    pass = 1'b0;
    n = 0;
    as_n <= 1'b0;
    ds0_n <= !ds;
    iack_n <= !ia;
    iackin_n <= !ia;
    write_n <= !wr;
    am <= m;
    addr <= a;
    d_i <= wd;
    while (!ack && n < 8) begin
      @(posedge clk);
      n++;
      pass |= !iackout_n;
      ack = dtack_oe;
      rd = d_o;
    end
    {as_n, ds0_n, iack_n, iackin_n} <= 4'hF;
    d_i <= ~wd; // Released lines must not keep showing the old byte.
    repeat (2) @(posedge clk);
  endtask
endmodule // vme_master

// ### verilog/sticky_flags.sv
// Sticky event flags with clear-on-read, a mask and one interrupt level.
`timescale 1ns/1ps
module sticky_flags #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] set,
  input  wire logic         rd_clr,
  input  wire logic [W-1:0] mask,
  output logic      [W-1:0] status,
  output logic              irq
);

  logic [W-1:0] status_ff;
  logic         irq_ff;
  wire  [W-1:0] nxt_status;

  // An event in the reading cycle survives the clear.
  assign nxt_status = (status_ff & {W{~rd_clr}}) | set;

  always_ff @(posedge clk) begin
    if (rst) begin
      status_ff <= '0;
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq_ff    <= |(nxt_status & mask);
    end
  end

  assign status = status_ff;
  assign irq    = irq_ff;

endmodule // sticky_flags

// ### verilog/vme_cfg_pkg.sv
// Shared constants and types for the short I/O slave and interrupter.
package vme_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Backplane address modifier codes for short I/O space.
  localparam logic [5:0] AM_SHORT_SUPER = 6'h2D;
  localparam logic [5:0] AM_SHORT_USER  = 6'h29;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses on the AXI4-Lite bus).
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_STATE  = 8'h0C;

  // Configuration register fields.
  localparam int CFG_PRIV_BIT = 0;
  localparam int CFG_BASE_LSB = 4;
  localparam int CFG_BASE_MSB = 15;
  localparam int CFG_LINE_LSB = 16;
  localparam int CFG_LINE_MSB = 18;
  localparam int CFG_PRIO_LSB = 20;
  localparam int CFG_PRIO_MSB = 22;
  localparam int CFG_VEC_LSB  = 24;
  localparam int CFG_VEC_MSB  = 31;

  // Non-privileged mode, base 1000 hex, line 2, code 2, vector 1A hex.
  localparam logic [31:0] CFG_RESET = 32'h1A22_1000;
  localparam logic [31:0] CFG_WMASK = 32'hFF77_FFF1;

  // Event bits of the status and mask registers.
  localparam int EV_W         = 4;
  localparam int EV_SLAVE_ACC = 0;
  localparam int EV_IACK_ANS  = 1;
  localparam int EV_IACK_PASS = 2;
  localparam int EV_CHIP_INT  = 3;
  localparam logic [EV_W-1:0] MASK_RESET = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_PERIOD_NS   = 100;
  localparam int CHIP_STROBE_NS  = 200;
  localparam int CHIP_STROBE_CYC =
    (CHIP_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHIP,
    ST_ACK,
    ST_IACK,
    ST_PASS,
    ST_WAIT
  } vme_state_t;

endpackage

// ### verilog/vme_slave_interrupter.sv
// Short I/O backplane slave decoder and release-on-acknowledge interrupter.
`timescale 1ns/1ps
// Notes on behaviour
// - Privileged-only strap accepts modifier code 2D hex alone.
// - Supervisor-and-user strap accepts modifier codes 2D or 29 hex.
// - Out of reset the access mode is non-privileged.
// - The board occupies one window of sixteen byte addresses.
// - Address bits fifteen to four are compared with the base address.
// - Address bits three to one go unchanged to the chip register select.
// - Only short 16-bit address modifier codes are answered.
// - Base bits fifteen to eight and seven to four are set separately.
// - The base address resets to 1000 hex.
// - One of the seven request lines, chosen by configuration, is driven; line code 0 drives none.
// - The request line resets to level two.
// - A matching acknowledge cycle gets the 8-bit status/ID vector.
// - A three-bit priority code, low bit first, marks our acknowledges.
// - The vector is an eight-bit configured value, bit seven most significant.
// - The vector resets to 1A hex.
// - The request line is released when its acknowledge is answered.
// - The daisy chain is served for all seven priority levels.
// - Address-only cycles are harmless; data moves as bytes on D7..D0.
module vme_slave_interrupter (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // Backplane side, sampled on CLK_SYS.
  input  wire logic        AS_N,
  input  wire logic        DS0_N,
  input  wire logic        DS1_N,
  input  wire logic        WRITE_N,
  input  wire logic        LWORD_N,
  input  wire logic        IACK_N,
  input  wire logic        IACKIN_N,
  input  wire logic [5:0]  AM,
  input  wire logic [15:1] ADDR,
  input  wire logic [7:0]  D_I,
  output logic      [7:0]  D_O,
  output logic             D_OE,
  output logic             DTACK_N_OE,
  output logic             IACKOUT_N,
  output logic      [7:1]  IRQ_N_OE,
  // Bus interface chip side.
  output logic             CHIP_CS_N,
  output logic             CHIP_RD_N,
  output logic             CHIP_WR_N,
  output logic      [2:0]  CHIP_RS,
  output logic      [7:0]  CHIP_DOUT,
  input  wire logic [7:0]  CHIP_DIN,
  input  wire logic        CHIP_INT,
  // AXI4-Lite register port.
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic      [1:0]  BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic      [31:0] RDATA,
  output logic      [1:0]  RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic             IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields.

  logic [31:0]                       cfg_ff;
  logic [vme_cfg_pkg::EV_W-1:0]      mask_ff;
  wire                               priv_only;
  wire  [11:0]                       base_addr;
  wire  [2:0]                        irq_line;
  wire  [2:0]                        prio_code;
  wire  [7:0]                        vector;

  assign priv_only = cfg_ff[vme_cfg_pkg::CFG_PRIV_BIT];
  assign base_addr = cfg_ff[vme_cfg_pkg::CFG_BASE_MSB:vme_cfg_pkg::CFG_BASE_LSB];
  assign irq_line  = cfg_ff[vme_cfg_pkg::CFG_LINE_MSB:vme_cfg_pkg::CFG_LINE_LSB];
  assign prio_code = cfg_ff[vme_cfg_pkg::CFG_PRIO_MSB:vme_cfg_pkg::CFG_PRIO_LSB];
  assign vector    = cfg_ff[vme_cfg_pkg::CFG_VEC_MSB:vme_cfg_pkg::CFG_VEC_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Backplane cycle decode.

  vme_cfg_pkg::vme_state_t state_ff;
  vme_cfg_pkg::vme_state_t nxt_state;
  logic [1:0]              cnt_ff;
  logic                    wr_cyc_ff;
  logic                    irq_pend_ff;
  logic                    chip_int_d_ff;

  wire am_super;
  wire am_user;
  wire am_ok;
  wire base_hit;
  wire byte_lane_ok;
  wire slave_cyc;
  wire slave_hit;
  wire iack_cyc;
  wire iack_mine;
  wire chip_done;

  assign am_super     = (AM == vme_cfg_pkg::AM_SHORT_SUPER);
  assign am_user      = (AM == vme_cfg_pkg::AM_SHORT_USER);
  // Any other code, wider spaces included, is simply not ours.
  assign am_ok        = am_super | (~priv_only & am_user);
  assign base_hit     = (ADDR[15:4] == base_addr);
  // Single odd bytes only: the chip sits on D7..D0 behind DS0.
  assign byte_lane_ok = ~DS0_N & DS1_N & LWORD_N;
  // No action until a data strobe falls, so address-only cycles pass.
  assign slave_cyc    = ~AS_N & IACK_N & ~DS0_N;
  assign slave_hit    = slave_cyc & am_ok & base_hit & byte_lane_ok;
  assign iack_cyc     = ~AS_N & ~IACK_N & ~IACKIN_N & ~DS0_N;
  // The level on ADDR[3:1] is checked against our code, low bit first.
  assign iack_mine    = iack_cyc & irq_pend_ff & (irq_line != 3'h0) &
                        (ADDR[3:1] == prio_code);
  assign chip_done    =
    (cnt_ff == 2'(vme_cfg_pkg::CHIP_STROBE_CYC - 1));

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      vme_cfg_pkg::ST_IDLE: begin
        if (iack_mine) begin
          nxt_state = vme_cfg_pkg::ST_IACK;
        end else if (iack_cyc) begin
          nxt_state = vme_cfg_pkg::ST_PASS;
        end else if (slave_hit) begin
          nxt_state = vme_cfg_pkg::ST_CHIP;
        end else if (slave_cyc) begin
          nxt_state = vme_cfg_pkg::ST_WAIT;
        end
      end
      vme_cfg_pkg::ST_CHIP: begin
        if (chip_done) begin
          nxt_state = vme_cfg_pkg::ST_ACK;
        end
      end
      vme_cfg_pkg::ST_ACK,
      vme_cfg_pkg::ST_IACK: begin
        if (DS0_N | AS_N) begin
          nxt_state = vme_cfg_pkg::ST_IDLE;
        end
      end
      vme_cfg_pkg::ST_PASS: begin
        if (IACKIN_N | AS_N) begin
          nxt_state = vme_cfg_pkg::ST_IDLE;
        end
      end
      vme_cfg_pkg::ST_WAIT: begin
        if (AS_N) begin
          nxt_state = vme_cfg_pkg::ST_IDLE;
        end
      end
      default: nxt_state = vme_cfg_pkg::ST_IDLE;
    endcase
  end

  wire enter_chip;
  wire enter_iack;
  wire enter_pass;
  wire chip_read_end;
  wire nxt_in_chip;
  wire nxt_drive_dtack;

  assign enter_chip    = (state_ff == vme_cfg_pkg::ST_IDLE) &
                         (nxt_state == vme_cfg_pkg::ST_CHIP);
  assign enter_iack    = (state_ff == vme_cfg_pkg::ST_IDLE) &
                         (nxt_state == vme_cfg_pkg::ST_IACK);
  assign enter_pass    = (state_ff == vme_cfg_pkg::ST_IDLE) &
                         (nxt_state == vme_cfg_pkg::ST_PASS);
  assign chip_read_end = (state_ff == vme_cfg_pkg::ST_CHIP) & chip_done;
  assign nxt_in_chip   = (nxt_state == vme_cfg_pkg::ST_CHIP);
  assign nxt_drive_dtack = (nxt_state == vme_cfg_pkg::ST_ACK) |
                           (nxt_state == vme_cfg_pkg::ST_IACK);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_ff <= vme_cfg_pkg::ST_IDLE;
      cnt_ff   <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= (state_ff == vme_cfg_pkg::ST_CHIP) ? cnt_ff + 2'h1 : 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chip strobes and backplane drivers.

  logic [7:0] d_o_ff;
  logic       d_oe_ff;
  logic       dtack_oe_ff;
  logic       iackout_n_ff;
  logic       cs_n_ff;
  logic       rd_n_ff;
  logic       wr_n_ff;
  logic [2:0] rs_ff;
  logic [7:0] chip_dout_ff;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wr_cyc_ff    <= 1'b0;
      rs_ff        <= 3'h0;
      chip_dout_ff <= 8'h00;
    end else if (enter_chip) begin
      wr_cyc_ff    <= ~WRITE_N;
      rs_ff        <= ADDR[3:1];
      chip_dout_ff <= D_I;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cs_n_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
    end else begin
      cs_n_ff <= ~nxt_in_chip;
      rd_n_ff <= ~(nxt_in_chip & (enter_chip ? WRITE_N : ~wr_cyc_ff));
      wr_n_ff <= ~(nxt_in_chip & (enter_chip ? ~WRITE_N : wr_cyc_ff));
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      d_o_ff <= 8'h00;
    end else if (enter_iack) begin
      d_o_ff <= vector;
    end else if (chip_read_end) begin
      d_o_ff <= CHIP_DIN;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      d_oe_ff      <= 1'b0;
      dtack_oe_ff  <= 1'b0;
      iackout_n_ff <= 1'b1;
    end else begin
      d_oe_ff      <= (nxt_state == vme_cfg_pkg::ST_IACK) |
                      ((nxt_state == vme_cfg_pkg::ST_ACK) & ~wr_cyc_ff);
      dtack_oe_ff  <= nxt_drive_dtack;
      iackout_n_ff <= ~(nxt_state == vme_cfg_pkg::ST_PASS);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request: raised by a rising chip interrupt, dropped on answer.

  wire       chip_int_rise;
  wire       nxt_irq_pend;
  wire [7:0] line_onehot;
  logic [7:1] irq_oe_ff;

  assign chip_int_rise = CHIP_INT & ~chip_int_d_ff;
  // A new chip event in the answering cycle keeps the request up.
  assign nxt_irq_pend  = chip_int_rise | (irq_pend_ff & ~enter_iack);
  assign line_onehot   = 8'(8'h01 << irq_line);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      chip_int_d_ff <= 1'b0;
      irq_pend_ff   <= 1'b0;
      irq_oe_ff     <= 7'h00;
    end else begin
      chip_int_d_ff <= CHIP_INT;
      irq_pend_ff   <= nxt_irq_pend;
      irq_oe_ff     <= nxt_irq_pend ? line_onehot[7:1] : 7'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  logic        aw_hold_ff;
  logic        w_hold_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  wire        aw_take;
  wire        w_take;
  wire        aw_have;
  wire        w_have;
  wire        do_write;
  wire [7:0]  wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire [31:0] byte_mask;
  wire [31:0] cfg_mask;
  wire        wr_cfg;
  wire        wr_msk;
  wire        wr_ok;
  wire        nxt_aw_hold;
  wire        nxt_w_hold;
  wire        nxt_bvalid;
  wire        ar_take;
  wire        nxt_rvalid;
  wire        rd_status;
  wire        rd_ok;
  wire [31:0] rd_word;
  wire [vme_cfg_pkg::EV_W-1:0] status;
  wire [vme_cfg_pkg::EV_W-1:0] events;
  wire        irq_level;

  assign aw_take   = AWVALID & awready_ff;
  assign w_take    = WVALID & wready_ff;
  assign aw_have   = aw_hold_ff | aw_take;
  assign w_have    = w_hold_ff | w_take;
  // One write is answered before the next is performed.
  assign do_write  = aw_have & w_have & ~bvalid_ff;
  assign wr_addr   = aw_hold_ff ? awaddr_ff : AWADDR;
  assign wr_data   = w_hold_ff ? wdata_ff : WDATA;
  assign wr_strb   = w_hold_ff ? wstrb_ff : WSTRB;
  assign byte_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                      {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign cfg_mask  = byte_mask & vme_cfg_pkg::CFG_WMASK;
  assign wr_cfg    = do_write & (wr_addr == vme_cfg_pkg::OFS_CONFIG);
  assign wr_msk    = do_write & (wr_addr == vme_cfg_pkg::OFS_MASK);
  assign wr_ok     = (wr_addr == vme_cfg_pkg::OFS_CONFIG) |
                     (wr_addr == vme_cfg_pkg::OFS_MASK);
  assign nxt_aw_hold = aw_have & ~do_write;
  assign nxt_w_hold  = w_have & ~do_write;
  assign nxt_bvalid  = do_write | (bvalid_ff & ~BREADY);

  assign ar_take    = ARVALID & arready_ff;
  assign nxt_rvalid = ar_take | (rvalid_ff & ~RREADY);
  assign rd_status  = ar_take & (ARADDR == vme_cfg_pkg::OFS_STATUS);
  assign rd_ok      = (ARADDR == vme_cfg_pkg::OFS_CONFIG) |
                      (ARADDR == vme_cfg_pkg::OFS_STATUS) |
                      (ARADDR == vme_cfg_pkg::OFS_MASK) |
                      (ARADDR == vme_cfg_pkg::OFS_STATE);
  assign rd_word    =
    (ARADDR == vme_cfg_pkg::OFS_CONFIG) ? cfg_ff :
    (ARADDR == vme_cfg_pkg::OFS_STATUS) ? 32'(status) :
    (ARADDR == vme_cfg_pkg::OFS_MASK)   ? 32'(mask_ff) :
    (ARADDR == vme_cfg_pkg::OFS_STATE)  ?
      32'({irq_pend_ff, chip_int_d_ff, state_ff}) : 32'h0000_0000;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cfg_ff  <= vme_cfg_pkg::CFG_RESET;
      mask_ff <= vme_cfg_pkg::MASK_RESET;
    end else begin
      if (wr_cfg) begin
        cfg_ff <= (cfg_ff & ~cfg_mask) | (wr_data & cfg_mask);
      end
      if (wr_msk & wr_strb[0]) begin
        mask_ff <= wr_data[vme_cfg_pkg::EV_W-1:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= vme_cfg_pkg::RESP_OKAY;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff  <= nxt_w_hold;
      if (aw_take) begin
        awaddr_ff <= AWADDR;
      end
      if (w_take) begin
        wdata_ff <= WDATA;
        wstrb_ff <= WSTRB;
      end
      awready_ff <= ~nxt_aw_hold;
      wready_ff  <= ~nxt_w_hold;
      bvalid_ff  <= nxt_bvalid;
      if (do_write) begin
        bresp_ff <= wr_ok ? vme_cfg_pkg::RESP_OKAY : vme_cfg_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= vme_cfg_pkg::RESP_OKAY;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      if (ar_take) begin
        rdata_ff <= rd_word;
        rresp_ff <= rd_ok ? vme_cfg_pkg::RESP_OKAY : vme_cfg_pkg::RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events, sticky status and the interrupt line to software.

  assign events[vme_cfg_pkg::EV_SLAVE_ACC] = chip_read_end;
  assign events[vme_cfg_pkg::EV_IACK_ANS]  = enter_iack;
  assign events[vme_cfg_pkg::EV_IACK_PASS] = enter_pass;
  assign events[vme_cfg_pkg::EV_CHIP_INT]  = chip_int_rise;

  sticky_flags #(
    .W (vme_cfg_pkg::EV_W)
  ) u_flags (
    .clk    (CLK_SYS),
    .rst    (RST),
    .set    (events),
    .rd_clr (rd_status),
    .mask   (mask_ff),
    .status (status),
    .irq    (irq_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign D_O        = d_o_ff;
  assign D_OE       = d_oe_ff;
  assign DTACK_N_OE = dtack_oe_ff;
  assign IACKOUT_N  = iackout_n_ff;
  assign IRQ_N_OE   = irq_oe_ff;
  assign CHIP_CS_N  = cs_n_ff;
  assign CHIP_RD_N  = rd_n_ff;
  assign CHIP_WR_N  = wr_n_ff;
  assign CHIP_RS    = rs_ff;
  assign CHIP_DOUT  = chip_dout_ff;
  assign AWREADY    = awready_ff;
  assign WREADY     = wready_ff;
  assign BVALID     = bvalid_ff;
  assign BRESP      = bresp_ff;
  assign ARREADY    = arready_ff;
  assign RVALID     = rvalid_ff;
  assign RDATA      = rdata_ff;
  assign RRESP      = rresp_ff;
  assign IRQ        = irq_level;

endmodule // vme_slave_interrupter
